// file: rtl/adc_seq_regs.svh
// register indices, field positions, reset values and timing counts of the converter
// assumes a 32-bit AXI4-Lite slave; byte address = 4 * register index
//
// Summary of operation
// - result format bit picks right or left justify
// - calibrate-next bit calibrates the next conversion
// - acquisition field selects 0 to 20 bit periods
// - clock field selects system divider or RC
// - RC clock adds one instruction cycle delay
// - write-once resolution bit: 1 ten, 0 twelve
// - pin bit 1 digital, 0 analog reads zero
// - reset returns all shared pins to analog
// - bit 7 requests band gap power, ORed
// - sleep conversions only with RC clock
// - successive approximation, one decision per bit period
// - completion loads result, clears go, sets flag
// - reset clears registers except result pair, sets ten-bit resolution, aborts conversion
// - power-on reset leaves result pair untouched
// - nonzero acquisition inserted after go set
// - two bit periods idle after each conversion
// - references selectable between rails and pins
// - go reads busy; on bit enables converter
// - channel codes: 0-12 pins, core, band gap
// - conversion lasts 11 or 13 bit periods
// - clearing go aborts, result keeps old value
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

`define IDX_PIN_CFG_LOW   22'h000f48
`define IDX_PIN_CFG_HIGH  22'h000f49
`define IDX_RESULT_HIGH   22'h000f4a
`define IDX_RESULT_LOW    22'h000f4b
`define IDX_IRQ_CTRL      22'h000f4c
`define IDX_CTRL_ONE      22'h000fc1
`define IDX_CTRL_ZERO     22'h000fc2
`define IDX_CFG3_HIGH     22'h300005

`define CZ_VREF_NEG_BIT   7
`define CZ_VREF_POS_BIT   6
`define CZ_CHAN_LSB       2
`define CZ_GO_BIT         1
`define CZ_ON_BIT         0
`define CO_JUSTIFY_BIT    7
`define CO_CAL_BIT        6
`define CO_ACQ_LSB        3
`define CO_CLK_LSB        0
`define PH_BANDGAP_BIT    7
`define CF_RES_BIT        1
`define IRQ_FLAG_BIT      0
`define IRQ_EN_BIT        1

`define CFG3_READ_BASE    8'hf9
`define RES_SEL_RESET     1'b1
`define CLK_SEL_RC        3'h3
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`define TCY_CLKS          3'h4
`define GAP_TICKS         5'h2
`define CONV_TICKS_TEN    5'hb
`define CONV_TICKS_TWELVE 5'hd

`endif

// file: rtl/adc_seq_pkg.sv
// types shared by the converter sequencer
// assumes nothing beyond the register header
package adc_seq_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_ACQ   = 3'b001,
    SEQ_DELAY = 3'b010,
    SEQ_CONV  = 3'b011,
    SEQ_GAP   = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic        sample_en;
    logic        convert_active;
    logic        cal_active;
    logic        twelve_bit;
    logic        vref_pos_ext;
    logic        vref_neg_ext;
    logic [3:0]  channel_sel;
    logic [11:0] dac_code;
  } ana_ctrl_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_have;
    logic [21:0] aw_idx;
    logic        w_have;
    logic [7:0]  wbyte;
    logic        wlane0;
    logic        vref_neg;
    logic        vref_pos;
    logic [3:0]  channel_sel;
    logic        go;
    logic        converter_on;
    logic        result_justify_sel;
    logic        calibrate_next;
    logic [2:0]  acq_time_sel;
    logic [2:0]  conv_clock_sel;
    logic        resolution_sel;
    logic        res_written;
    logic [12:0] pin_digital_sel;
    logic        bandgap_enable;
    logic        conv_done_irq_flag;
    logic        conv_done_irq_enable;
    seq_state_t  seq;
    logic [5:0]  div_cnt;
    logic [4:0]  tick_cnt;
    logic [2:0]  dly_cnt;
    logic [11:0] sar;
    logic [3:0]  bit_pos;
    ana_ctrl_t   ana;
    logic        bandgap_req;
    logic [12:0] pin_digital_in;
    logic [12:0] pin_analog;
  } state_t;

endpackage : adc_seq_pkg

// file: rtl/adc_sequencer_config.sv
// converter control: AXI4-Lite registers, bit clock, acquisition and SAR sequencer
// assumes comparator and rc tick inputs synchronous to clk
`timescale 1ns/1ps
`include "adc_seq_regs.svh"

module adc_sequencer_config
  import adc_seq_pkg::*;
#(
  parameter int ADDR_W   = 24,
  parameter int NUM_PINS = 13
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rc_osc_tick,
  input  wire logic              sleep_mode,
  input  wire logic              comp_above,
  input  wire logic              other_bandgap_req,
  input  wire logic [12:0]       pin_in,
  output ana_ctrl_t              ana_ctrl,
  output logic                   bandgap_power_req,
  output logic [12:0]            pin_digital_in,
  output logic [12:0]            pin_analog,
  output logic                   conv_done_irq_flag
);

  if (ADDR_W < 24) begin : g_addr_chk
    $error("ADDR_W must be at least 24");
  end
  if (NUM_PINS != 13) begin : g_pin_chk
    $error("NUM_PINS must be 13");
  end

  // bit period length in clk cycles, minus one
  function automatic logic [5:0] div_last(input logic [2:0] sel);
    case (sel)
      3'h0:    div_last = 6'h01;
      3'h1:    div_last = 6'h07;
      3'h2:    div_last = 6'h1f;
      3'h4:    div_last = 6'h03;
      3'h5:    div_last = 6'h0f;
      default: div_last = 6'h3f;
    endcase
  endfunction : div_last

  function automatic logic [4:0] acq_ticks(input logic [2:0] sel);
    case (sel)
      3'h7:    acq_ticks = 5'h14;
      3'h6:    acq_ticks = 5'h10;
      3'h5:    acq_ticks = 5'h0c;
      3'h4:    acq_ticks = 5'h08;
      3'h3:    acq_ticks = 5'h06;
      3'h2:    acq_ticks = 5'h04;
      3'h1:    acq_ticks = 5'h02;
      default: acq_ticks = 5'h00;
    endcase
  endfunction : acq_ticks

  function automatic logic [15:0] justify(input logic [11:0] sar, input logic ten,
                                          input logic right);
    if (ten) begin
      justify = right ? {6'h00, sar[9:0]} : {sar[9:0], 6'h00};
    end else begin
      justify = right ? {4'h0, sar} : {sar, 4'h0};
    end
  endfunction : justify

  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  state_t      st_reg;
  state_t      st_next;
  logic [15:0] result_reg;
  logic [15:0] result_next;
  logic        result_we;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  logic [4:0]  conv_len;
  logic [4:0]  acq_len;
  logic        use_rc;
  logic        bit_tick;
  logic        ten_bit;
  logic [21:0] rd_idx;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic        busy;
  logic        do_write;

  always_comb begin
    ten_bit  = st_reg.resolution_sel;
    conv_len = ten_bit ? `CONV_TICKS_TEN : `CONV_TICKS_TWELVE;
    acq_len  = acq_ticks(st_reg.acq_time_sel);
    use_rc   = (st_reg.conv_clock_sel == `CLK_SEL_RC);
    // in sleep only the rc clock keeps running
    if (use_rc) begin
      bit_tick = rc_osc_tick;
    end else begin
      bit_tick = !sleep_mode && (st_reg.div_cnt == div_last(st_reg.conv_clock_sel));
    end
    busy = (st_reg.seq == SEQ_ACQ) || (st_reg.seq == SEQ_DELAY) || (st_reg.seq == SEQ_CONV);

    rd_idx  = s_axi_araddr[23:2];
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (rd_idx)
      `IDX_PIN_CFG_LOW:  rd_byte = st_reg.pin_digital_sel[7:0];
      `IDX_PIN_CFG_HIGH: rd_byte = {st_reg.bandgap_enable, 2'b00,
                                    st_reg.pin_digital_sel[12:8]};
      `IDX_RESULT_HIGH:  rd_byte = result_reg[15:8];
      `IDX_RESULT_LOW:   rd_byte = result_reg[7:0];
      `IDX_IRQ_CTRL:     rd_byte = {6'h00, st_reg.conv_done_irq_enable,
                                    st_reg.conv_done_irq_flag};
      `IDX_CTRL_ONE:     rd_byte = {st_reg.result_justify_sel, st_reg.calibrate_next,
                                    st_reg.acq_time_sel, st_reg.conv_clock_sel};
      `IDX_CTRL_ZERO:    rd_byte = {st_reg.vref_neg, st_reg.vref_pos, st_reg.channel_sel,
                                    st_reg.go, st_reg.converter_on};
      `IDX_CFG3_HIGH:    rd_byte = `CFG3_READ_BASE | {6'h00, st_reg.resolution_sel, 1'b0};
      default:           rd_hit  = 1'b0;
    endcase

    st_next     = st_reg;
    result_next = result_reg;
    result_we   = 1'b0;
    do_write    = 1'b0;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.aw_idx  = s_axi_awaddr[23:2];
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.wbyte  = s_axi_wdata[7:0];
      st_next.wlane0 = s_axi_wstrb[0];
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      do_write        = st_reg.wlane0;
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = `RESP_OKAY;
      case (st_reg.aw_idx)
        `IDX_PIN_CFG_LOW, `IDX_PIN_CFG_HIGH, `IDX_RESULT_HIGH, `IDX_RESULT_LOW,
        `IDX_IRQ_CTRL, `IDX_CTRL_ONE, `IDX_CTRL_ZERO, `IDX_CFG3_HIGH: ;
        default: begin
          st_next.bresp = `RESP_SLVERR;
          do_write      = 1'b0;
        end
      endcase
    end
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready  = !st_next.w_have && !st_next.bvalid;

    if (do_write) begin
      case (st_reg.aw_idx)
        `IDX_PIN_CFG_LOW: st_next.pin_digital_sel[7:0] = st_reg.wbyte;
        `IDX_PIN_CFG_HIGH: begin
          st_next.pin_digital_sel[12:8] = st_reg.wbyte[4:0];
          st_next.bandgap_enable        = st_reg.wbyte[`PH_BANDGAP_BIT];
        end
        `IDX_RESULT_HIGH: begin
          result_next = {st_reg.wbyte, result_reg[7:0]};
          result_we   = 1'b1;
        end
        `IDX_RESULT_LOW: begin
          result_next = {result_reg[15:8], st_reg.wbyte};
          result_we   = 1'b1;
        end
        `IDX_IRQ_CTRL: begin
          st_next.conv_done_irq_flag   = st_reg.wbyte[`IRQ_FLAG_BIT];
          st_next.conv_done_irq_enable = st_reg.wbyte[`IRQ_EN_BIT];
        end
        `IDX_CTRL_ONE: begin
          st_next.result_justify_sel = st_reg.wbyte[`CO_JUSTIFY_BIT];
          st_next.calibrate_next     = st_reg.wbyte[`CO_CAL_BIT];
          st_next.acq_time_sel       = st_reg.wbyte[`CO_ACQ_LSB +: 3];
          st_next.conv_clock_sel     = st_reg.wbyte[`CO_CLK_LSB +: 3];
        end
        `IDX_CTRL_ZERO: begin
          st_next.vref_neg     = st_reg.wbyte[`CZ_VREF_NEG_BIT];
          st_next.vref_pos     = st_reg.wbyte[`CZ_VREF_POS_BIT];
          st_next.channel_sel  = st_reg.wbyte[`CZ_CHAN_LSB +: 4];
          st_next.converter_on = st_reg.wbyte[`CZ_ON_BIT];
          // go only takes when the module was already on
          st_next.go = st_reg.wbyte[`CZ_GO_BIT] && st_reg.converter_on;
        end
        `IDX_CFG3_HIGH: begin
          if (!st_reg.res_written) begin
            st_next.resolution_sel = st_reg.wbyte[`CF_RES_BIT];
            st_next.res_written    = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // read channel
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = {24'h000000, rd_byte};
      st_next.rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    st_next.arready = !st_next.rvalid;

    // bit clock divider
    if (bit_tick || use_rc) begin
      st_next.div_cnt = 6'h00;
    end else if (!sleep_mode) begin
      st_next.div_cnt = st_reg.div_cnt + 6'h01;
    end

    // sequencer
    if (busy && !st_next.go) begin
      st_next.seq      = SEQ_GAP;
      st_next.tick_cnt = 5'h00;
    end else begin
      unique case (st_reg.seq)
        SEQ_IDLE: begin
          if (st_next.go && st_next.converter_on) begin
            st_next.tick_cnt = 5'h00;
            if (acq_len != 5'h00) begin
              st_next.seq = SEQ_ACQ;
            end else if (use_rc) begin
              st_next.seq     = SEQ_DELAY;
              st_next.dly_cnt = 3'h0;
            end else begin
              st_next.seq     = SEQ_CONV;
              st_next.bit_pos = ten_bit ? 4'h9 : 4'hb;
              st_next.sar     = ten_bit ? 12'h200 : 12'h800;
            end
          end
        end
        SEQ_ACQ: begin
          if (bit_tick) begin
            if (st_reg.tick_cnt == acq_len - 5'h01) begin
              st_next.tick_cnt = 5'h00;
              if (use_rc) begin
                st_next.seq     = SEQ_DELAY;
                st_next.dly_cnt = 3'h0;
              end else begin
                st_next.seq     = SEQ_CONV;
                st_next.bit_pos = ten_bit ? 4'h9 : 4'hb;
                st_next.sar     = ten_bit ? 12'h200 : 12'h800;
              end
            end else begin
              st_next.tick_cnt = st_reg.tick_cnt + 5'h01;
            end
          end
        end
        SEQ_DELAY: begin
          if (st_reg.dly_cnt == `TCY_CLKS - 3'h1) begin
            st_next.seq      = SEQ_CONV;
            st_next.tick_cnt = 5'h00;
            st_next.bit_pos  = ten_bit ? 4'h9 : 4'hb;
            st_next.sar      = ten_bit ? 12'h200 : 12'h800;
          end else begin
            st_next.dly_cnt = st_reg.dly_cnt + 3'h1;
          end
        end
        SEQ_CONV: begin
          if (bit_tick) begin
            // one comparator decision per bit period, msb first
            if (st_reg.tick_cnt < (ten_bit ? 5'h0a : 5'h0c)) begin
              st_next.sar[st_reg.bit_pos] = comp_above;
              if (st_reg.bit_pos != 4'h0) begin
                st_next.sar[st_reg.bit_pos - 4'h1] = 1'b1;
                st_next.bit_pos                    = st_reg.bit_pos - 4'h1;
              end
            end
            if (st_reg.tick_cnt == conv_len - 5'h01) begin
              result_next = justify(st_next.sar, ten_bit,
                                    st_reg.result_justify_sel);
              result_we                  = 1'b1;
              st_next.go                 = 1'b0;
              st_next.conv_done_irq_flag = 1'b1;
              st_next.seq                = SEQ_GAP;
              st_next.tick_cnt           = 5'h00;
            end else begin
              st_next.tick_cnt = st_reg.tick_cnt + 5'h01;
            end
          end
        end
        SEQ_GAP: begin
          if (bit_tick) begin
            if (st_reg.tick_cnt == `GAP_TICKS - 5'h01) begin
              st_next.seq      = SEQ_IDLE;
              st_next.tick_cnt = 5'h00;
            end else begin
              st_next.tick_cnt = st_reg.tick_cnt + 5'h01;
            end
          end
        end
        default: st_next.seq = SEQ_IDLE;
      endcase
    end
    if (!st_next.converter_on) begin
      st_next.seq = SEQ_IDLE;
      st_next.go  = 1'b0;
    end

    // registered outputs to the analog side and pins
    st_next.ana.sample_en      = st_next.converter_on && (st_next.seq != SEQ_CONV);
    st_next.ana.convert_active = (st_next.seq == SEQ_CONV);
    st_next.ana.cal_active     = (st_next.seq == SEQ_CONV) && st_next.calibrate_next;
    st_next.ana.twelve_bit     = !st_next.resolution_sel;
    st_next.ana.vref_pos_ext   = st_next.vref_pos;
    st_next.ana.vref_neg_ext   = st_next.vref_neg;
    st_next.ana.channel_sel    = st_next.channel_sel;
    st_next.ana.dac_code       = st_next.sar;
    st_next.bandgap_req        = st_next.bandgap_enable || other_bandgap_req;
    st_next.pin_digital_in     = pin_in & st_next.pin_digital_sel;
    st_next.pin_analog         = ~st_next.pin_digital_sel;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg                <= '0;
      st_reg.awready        <= 1'b1;
      st_reg.wready         <= 1'b1;
      st_reg.arready        <= 1'b1;
      st_reg.seq            <= SEQ_IDLE;
      st_reg.resolution_sel <= `RES_SEL_RESET;
      st_reg.pin_analog     <= 13'h1fff;
    end else begin
      st_reg <= st_next;
    end
  end

  // no reset: contents survive any reset and are unknown at power-up
  always_ff @(posedge clk) begin
    if (result_we) begin
      result_reg <= result_next;
    end
  end

  assign s_axi_awready      = st_reg.awready;
  assign s_axi_wready       = st_reg.wready;
  assign s_axi_bvalid       = st_reg.bvalid;
  assign s_axi_bresp        = st_reg.bresp;
  assign s_axi_arready      = st_reg.arready;
  assign s_axi_rvalid       = st_reg.rvalid;
  assign s_axi_rresp        = st_reg.rresp;
  assign s_axi_rdata        = st_reg.rdata;
  assign ana_ctrl           = st_reg.ana;
  assign bandgap_power_req  = st_reg.bandgap_req;
  assign pin_digital_in     = st_reg.pin_digital_in;
  assign pin_analog         = st_reg.pin_analog;
  assign conv_done_irq_flag = st_reg.conv_done_irq_flag;

endmodule : adc_sequencer_config

// file: test/adc_seq_sva.sv
// assertions on the converter sequencer ports
// assumes a bind onto adc_sequencer_config
`timescale 1ns/1ps
module adc_seq_sva
  import adc_seq_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        other_bandgap_req,
  input wire logic [12:0] pin_in,
  input wire ana_ctrl_t   ana_ctrl,
  input wire logic        bandgap_power_req,
  input wire logic [12:0] pin_digital_in,
  input wire logic [12:0] pin_analog,
  input wire logic        conv_done_irq_flag
);
  logic [1:0] up_cnt;
  wire        up = (up_cnt == 2'h3);
  // masks the reset sync
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) up_cnt <= 2'h0;
    else if (!up) up_cnt <= up_cnt + 2'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_bandgap_or: assert property (up && other_bandgap_req |=> bandgap_power_req)
    else $error("band gap request dropped");
  a_analog_zero: assert property ((pin_digital_in & pin_analog) == 13'h0)
    else $error("analog pin reads nonzero");
  a_digital_pass: assert property (up |-> pin_digital_in == ($past(pin_in) & ~pin_analog))
    else $error("digital pin not passed");
  a_reset_state: assert property ($rose(resetn) |-> pin_analog == 13'h1fff && !ana_ctrl.convert_active)
    else $error("reset state wrong");
  a_flag_source: assert property ($rose(conv_done_irq_flag) |->
    $past(ana_ctrl.convert_active) || $past(ana_ctrl.convert_active, 2))
    else $error("flag without conversion");
  a_cal_in_conv: assert property (ana_ctrl.cal_active |-> ana_ctrl.convert_active)
    else $error("cal outside conversion");
  a_hold_conv: assert property (ana_ctrl.convert_active |-> !ana_ctrl.sample_en)
    else $error("sampling during conversion");
  a_idle_gap: assert property ($fell(ana_ctrl.convert_active) |-> !ana_ctrl.convert_active [*3])
    else $error("no idle gap");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  c_conv_end: cover property ($fell(ana_ctrl.convert_active));
  c_cal_run: cover property (ana_ctrl.cal_active);
  c_flag_set: cover property ($rose(conv_done_irq_flag));
endmodule : adc_seq_sva

// file: test/adc_analog_model.sv
// analog side: comparator on a held input, internal rc tick
// assumes ana_ctrl from adc_sequencer_config on the same clock
`timescale 1ns/1ps
module adc_analog_model
  import adc_seq_pkg::*;
#(
  parameter int RC_DIV = 5
) (
  input  wire logic        clk,
  input  wire ana_ctrl_t   ana_ctrl,
  input  wire logic [11:0] vin,
  output logic             comp_above,
  output logic             rc_osc_tick
);
  logic [3:0] rc_cnt = 4'h0;
  logic       tog    = 1'b0;
  // rc oscillator keeps running in sleep
  always_ff @(posedge clk) begin
    rc_cnt <= (rc_cnt == 4'(RC_DIV - 1)) ? 4'h0 : rc_cnt + 4'h1;
    tog    <= ~tog;
  end
  assign rc_osc_tick = (rc_cnt == 4'h0);
  // meaningless outside conversion
  assign comp_above = ana_ctrl.convert_active ? (vin >= ana_ctrl.dac_code) : tog;
endmodule : adc_analog_model

// file: test/adc_sequencer_config_tb.sv
// self-checking bench for the converter sequencer
// assumes the analog model beside it and a 20 MHz clock
`timescale 1ns/1ps
`include "adc_seq_regs.svh"
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module adc_sequencer_config_tb
  import adc_seq_pkg::*;
;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [23:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        rc_osc_tick, sleep_mode, comp_above, other_bandgap_req, bandgap_power_req;
  logic        conv_done_irq_flag;
  logic [12:0] pin_in, pin_digital_in, pin_analog;
  logic [11:0] vin;
  logic [7:0]  d, e;
  ana_ctrl_t   ana_ctrl;
  int          n_fail = 0;
  int          n_tests = 0;
  int          a0 = 0;
  int          acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int          div_tab[8] = '{2, 8, 32, 5, 4, 16, 64, 64};
  always #25 clk = ~clk;
  adc_sequencer_config i_adc_sequencer_config (
    .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rc_osc_tick, .sleep_mode, .comp_above, .other_bandgap_req, .pin_in, .ana_ctrl,
    .bandgap_power_req, .pin_digital_in, .pin_analog, .conv_done_irq_flag);
  adc_analog_model i_adc_analog_model (.clk, .ana_ctrl, .vin, .comp_above, .rc_osc_tick);
  task automatic complete_run(input bit hung);
    if (hung) n_fail++;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [21:0] idx, input logic [7:0] v, input logic [1:0] er = 2'h0);
    int k = 0;
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 200);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
    if (k >= 200) complete_run(1);
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [21:0] idx, output logic [7:0] v, input logic [1:0] er = 2'h0);
    int k = 0;
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 200);
    v = s_axi_rdata[7:0];
    s_axi_rready <= 1'b0;
    `CHK("rresp", er, s_axi_rresp)
    if (k >= 200) complete_run(1);
    @(posedge clk);
  endtask : rd
  task automatic wait_conv();
    int k;
    for (k = 0; k < 3000 && ana_ctrl.convert_active !== 1'b1; k++) @(posedge clk);
    if (k >= 3000) complete_run(1);
  endtask : wait_conv
  task automatic t_reset();
    rd(`IDX_CTRL_ONE, d);
    `CHK("ctrl_one", 8'h00, d)
    rd(`IDX_PIN_CFG_LOW, d);
    `CHK("pin_low", 8'h00, d)
    rd(`IDX_CFG3_HIGH, d);
    `CHK("cfg3", 8'hfb, d)
    rd(22'h000f50, d, `RESP_SLVERR);
    `CHK("pin_analog", 13'h1fff, pin_analog)
    $display("reset test done");
  endtask : t_reset
  task automatic t_pins();
    wr(`IDX_PIN_CFG_LOW, 8'hff);
    wr(`IDX_PIN_CFG_HIGH, 8'hbf);
    rd(`IDX_PIN_CFG_HIGH, d);
    `CHK("pin_high", 8'h9f, d)
    `CHK("dig_in", 13'h1aaa, pin_digital_in)
    `CHK("bg_on", 1'b1, bandgap_power_req)
    wr(`IDX_PIN_CFG_HIGH, 8'h00);
    other_bandgap_req <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("dig_mix", 13'h00aa, pin_digital_in)
    `CHK("bg_other", 1'b1, bandgap_power_req)
    other_bandgap_req <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("bg_off", 1'b0, bandgap_power_req)
    $display("pin test done");
  endtask : t_pins
  task automatic t_chan();
    for (int i = 0; i < 16; i++) begin
      wr(`IDX_CTRL_ZERO, {i[1], i[0], i[3:0], 2'b01});
      @(posedge clk);
      `CHK("chan", i[3:0], ana_ctrl.channel_sel)
      `CHK("vref", i[1:0], {ana_ctrl.vref_neg_ext, ana_ctrl.vref_pos_ext})
    end
    wr(`IDX_CTRL_ZERO, 8'h01);
    $display("channel test done");
  endtask : t_chan
  task automatic conv(input logic [7:0] c1, input int dv, tk, aq, input logic [15:0] res);
    int a = 0, h = 0;
    logic cs = 1'b0;
    wr(`IDX_CTRL_ONE, c1);
    wr(`IDX_CTRL_ZERO, 8'h03);
    if (ana_ctrl.convert_active === 1'b1) h = 2;
    for (int k = 0; k < 4000 && !(h > 0 && ana_ctrl.convert_active !== 1'b1); k++) begin
      @(posedge clk);
      if (ana_ctrl.convert_active === 1'b1) h++;
      else if (h == 0) a++;
      if (ana_ctrl.cal_active === 1'b1) cs = 1'b1;
    end
    `CHK("conv_len", 1'b1, h >= (tk - 1) * dv && h <= (tk + 1) * dv)
    if (c1[5:3] == 3'h0) a0 = a;
    else `CHK("acq", 1'b1, a - a0 >= (aq - 2) * dv && a - a0 <= (aq + 2) * dv)
    `CHK("cal", {c1[6], tk > 11}, {cs, ana_ctrl.twelve_bit})
    rd(`IDX_CTRL_ZERO, d);
    `CHK("go_done", 8'h01, d)
    rd(`IDX_RESULT_HIGH, d);
    rd(`IDX_RESULT_LOW, e);
    if (!c1[6]) `CHK("result", res, {d, e})
    rd(`IDX_IRQ_CTRL, d);
    `CHK("flag", 2'h3, {d[0], conv_done_irq_flag})
    wr(`IDX_IRQ_CTRL, 8'h00);
    $display("conversion %0h done", c1);
  endtask : conv
  task automatic t_abort();
    wr(`IDX_RESULT_HIGH, 8'h5a);
    wr(`IDX_RESULT_LOW, 8'h3c);
    wr(`IDX_CTRL_ONE, 8'h86);
    wr(`IDX_CTRL_ZERO, 8'h03);
    wait_conv();
    wr(`IDX_CTRL_ZERO, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("aborted", 1'b0, ana_ctrl.convert_active)
    rd(`IDX_RESULT_HIGH, d);
    rd(`IDX_RESULT_LOW, e);
    rd(`IDX_IRQ_CTRL, d);
    `CHK("kept", 9'h03c, {d[0], e})
    wr(`IDX_CTRL_ZERO, 8'h03);
    wait_conv();
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("rst_abort", 1'b0, ana_ctrl.convert_active)
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`IDX_CTRL_ZERO, d);
    `CHK("rst_ctrl", 8'h00, d)
    rd(`IDX_RESULT_HIGH, d);
    `CHK("rst_result", 8'h5a, d)
    $display("abort test done");
  endtask : t_abort
  task automatic t_twelve();
    wr(`IDX_CFG3_HIGH, 8'hf9);
    wr(`IDX_CFG3_HIGH, 8'hfb);
    rd(`IDX_CFG3_HIGH, d);
    `CHK("once", 8'hf9, d)
    wr(`IDX_CTRL_ZERO, 8'h01);
    vin <= 12'ha5c;
    conv(8'h80, 2, 13, 0, 16'h0a5c);
    conv(8'h00, 2, 13, 0, 16'ha5c0);
  endtask : t_twelve
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 80'h0;
    s_axi_wstrb = 4'hf;
    {sleep_mode, other_bandgap_req} = 2'h0;
    pin_in = 13'h1aaa;
    vin = 12'hfff;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_pins();
    t_chan();
    for (int j = 0; j < 8; j++) conv({2'b10, 3'(j), 3'h0}, 2, 11, acq_tab[j], 16'h03ff);
    conv(8'h00, 2, 11, 0, 16'hffc0);
    for (int j = 1; j < 8; j++) begin
      sleep_mode <= (j == 3);
      conv({5'h10, 3'(j)}, div_tab[j], 11, 0, 16'h03ff);
    end
    sleep_mode <= 1'b0;
    conv(8'hc0, 2, 11, 0, 16'h0);
    t_abort();
    t_twelve();
    complete_run(0);
  end
endmodule : adc_sequencer_config_tb
bind adc_sequencer_config adc_seq_sva i_adc_seq_sva (.clk, .resetn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .other_bandgap_req, .pin_in, .ana_ctrl, .bandgap_power_req,
  .pin_digital_in, .pin_analog, .conv_done_irq_flag);
